/* File: hw/fsp_status_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fsp_cfg.svh"
module fsp_status_top
#(
  parameter logic [`FSP_TIMER_W-1:0] STATUS_WRITE_CYCLES =
    `FSP_STATUS_WRITE_CYCLES
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // serial link pins
  input wire logic sclk_in,
  input wire logic device_select_n_in,
  input wire logic [3:0] dq_in,
  output logic [3:0] dq_out,
  output logic [3:0] dq_oe_out,
  input wire logic write_guard_n_in,
  input wire logic pause_n_in,
  // array datapath handshake
  output logic arr_start_out,
  output fsp_pkg::fsp_arr_req_t arr_req_out,
  input wire logic arr_done_in,
  // protection state to the datapath
  output fsp_pkg::fsp_prot_t prot_out,
  output fsp_pkg::fsp_otp_t otp_out,
  output logic write_enable_latch_out,
  output logic write_in_progress_out,
  output logic hardware_protected_mode_out,
  output logic quad_peripheral_mode_out,
  output logic otp_mode_out,
  output logic link_hold_out
);

  // synced pins
  logic [`FSP_PIN_W-1:0] pins_s;
  logic cs_n_s, guard_n_s, pause_n_s, sclk_s;
  logic [3:0] dq_s;
  logic sclk_d_reg, cs_n_d_reg;

  // state registers
  fsp_pkg::fsp_mode_t mode_reg;
  fsp_pkg::fsp_width_t width_reg;
  fsp_pkg::fsp_prot_t prot_reg;
  fsp_pkg::fsp_otp_t otp_reg;
  fsp_pkg::fsp_arr_req_t req_reg;
  logic wel_reg, vol_en_reg, arr_busy_reg, arr_start_reg;
  logic pend_otp_reg;
  logic [7:0] pend_data_reg;

  // link shift state
  logic [`FSP_CNT_W-1:0] cnt_reg, cnt_next, step;
  logic [31:0] in_sr_reg, in_sr_next;
  logic [7:0] op_reg, data_reg;
  logic [23:0] addr_reg;
  logic [7:0] tx_sr_reg;
  logic [3:0] tx_left_reg;
  logic [3:0] dout_reg;

  // decoded wires
  logic quad, otp, hold, guard_low, hardware_protected_mode, write_in_progress, busy, selected;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise, rd_active, tx_load;
  logic [7:0] status_byte, tx_src;
  logic tmr_busy, tmr_done, tmr_start;
  logic frame_ok, exact8, exact16, exact32;
  logic cmd_write_enable_cmd, cmd_write_disable_cmd, cmd_vwren, cmd_qen, cmd_qex, cmd_otp;
  logic cmd_status_write_cmd, status_write_cmd_nv, status_write_cmd_vol;
  logic cmd_pp, cmd_se, cmd_hbe, cmd_be, cmd_ce, cmd_arr;
  fsp_pkg::fsp_arr_kind_t arr_kind;
  logic apply_now, apply_otp;
  logic [7:0] apply_data;
  fsp_pkg::fsp_otp_t otp_merged;

  // saturating bit counter advance
  function automatic logic [`FSP_CNT_W-1:0] cnt_add
  (
    input logic [`FSP_CNT_W-1:0] cur,
    input logic [`FSP_CNT_W-1:0] inc
  );
    logic [`FSP_CNT_W:0] sum;
    sum = {1'b0, cur} + {1'b0, inc};
    cnt_add = sum[`FSP_CNT_W] ? `FSP_BITS_MAX : sum[`FSP_CNT_W-1:0];
  endfunction

  fsp_pin_sync u_sync
  (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .raw_in({device_select_n_in, write_guard_n_in, pause_n_in, sclk_in,
      dq_in}),
    .sync_out(pins_s)
  );

  fsp_op_timer #(.CYCLES(STATUS_WRITE_CYCLES)) u_wr_timer
  (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .start_in(tmr_start),
    .busy_out(tmr_busy),
    .done_out(tmr_done)
  );

  // pin split and mode decode
  assign cs_n_s = pins_s[7];
  assign guard_n_s = pins_s[6];
  assign pause_n_s = pins_s[5];
  assign sclk_s = pins_s[4];
  assign dq_s = pins_s[3:0];
  assign quad = (width_reg == fsp_pkg::WIDTH_QUAD);
  assign otp = (mode_reg == fsp_pkg::MODE_OTP);
  assign step = quad ? `FSP_STEP_QUAD : `FSP_STEP_SINGLE;

  // guard and pause pins, ignored once pin disable is set or in quad
  assign hold = !pause_n_s && !otp_reg.pin_disable && !quad;
  assign guard_low = !guard_n_s && !otp_reg.pin_disable && !quad;
  assign hardware_protected_mode = prot_reg.status_lock && guard_low;

  // busy sources
  assign write_in_progress = tmr_busy || arr_busy_reg;
  assign busy = write_in_progress;

  // link edges, serial clock edges frozen while paused
  assign selected = !cs_n_s;
  assign sclk_rise = selected && !hold && sclk_s && !sclk_d_reg;
  assign sclk_fall = selected && !hold && !sclk_s && sclk_d_reg;
  assign cs_fall = !cs_n_s && cs_n_d_reg;
  assign cs_rise = cs_n_s && !cs_n_d_reg;

  // input shifting, four lines in quad mode
  assign cnt_next = cnt_add(cnt_reg, step);
  assign in_sr_next = quad ? {in_sr_reg[27:0], dq_s}
                           : {in_sr_reg[30:0], dq_s[0]};

  // edge history
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      sclk_d_reg <= 1'b0;
      cs_n_d_reg <= 1'b1;
    end
    else
    begin
      sclk_d_reg <= sclk_s;
      cs_n_d_reg <= cs_n_s;
    end
  end

  // receive: opcode, data byte and address captured at fixed counts
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      cnt_reg <= '0;
      in_sr_reg <= '0;
      op_reg <= 8'h00;
      data_reg <= 8'h00;
      addr_reg <= 24'h000000;
    end
    else if (cs_fall || cs_rise)
      cnt_reg <= '0; // stale count would drive pins at next select
    else if (sclk_rise)
    begin
      cnt_reg <= cnt_next;
      in_sr_reg <= in_sr_next;
      if (cnt_next == `FSP_BITS_OPCODE)
        op_reg <= in_sr_next[7:0];
      if (cnt_next == `FSP_BITS_STATUS_WRITE)
        data_reg <= in_sr_next[7:0];
      if (cnt_next == `FSP_BITS_ADDR)
        addr_reg <= in_sr_next[23:0];
    end
  end

  // status byte in the active layout
  assign status_byte = otp
    ? {otp_reg.security_lock_0, otp_reg.pin_disable, 1'b0,
       otp_reg.granularity_select, otp_reg.top_bottom_select,
       otp_reg.security_lock_1, otp_reg.security_lock_2, write_in_progress}
    : {prot_reg.status_lock, prot_reg.boot_lock_enable,
       prot_reg.block_protect, wel_reg, write_in_progress};

  // read-status output, any time, repeated while selected
  assign rd_active = selected && (cnt_reg >= `FSP_BITS_OPCODE)
    && (op_reg == `FSP_OP_READ_STATUS);
  assign tx_load = (tx_left_reg == 4'h0);
  assign tx_src = tx_load ? status_byte : tx_sr_reg;

  // msb first on each falling serial clock edge
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || cs_fall)
    begin
      tx_sr_reg <= 8'h00;
      tx_left_reg <= 4'h0;
      dout_reg <= 4'h0;
    end
    else if (sclk_fall && rd_active)
    begin
      dout_reg <= quad ? tx_src[7:4] : {3'b000, tx_src[7]};
      tx_sr_reg <= quad ? {tx_src[3:0], 4'h0} : {tx_src[6:0], 1'b0};
      tx_left_reg <= (tx_load ? 4'h8 : tx_left_reg)
        - (quad ? 4'h4 : 4'h1);
    end
  end

  // pin drive: DQ1 in single mode, all four in quad
  assign dq_out = quad ? dout_reg : {2'b00, dout_reg[0], 1'b0};
  assign dq_oe_out = !rd_active ? 4'h0 : (quad ? 4'hF : 4'h2);

  // frame end decode, only whole frames while idle
  assign frame_ok = cs_rise && !busy;
  assign exact8 = (cnt_reg == `FSP_BITS_OPCODE);
  assign exact16 = (cnt_reg == `FSP_BITS_STATUS_WRITE);
  assign exact32 = (cnt_reg == `FSP_BITS_ADDR);
  assign cmd_write_enable_cmd = frame_ok && exact8 && op_reg == `FSP_OP_WRITE_ENABLE;
  assign cmd_write_disable_cmd = frame_ok && exact8
    && op_reg == `FSP_OP_WRITE_DISABLE;
  assign cmd_vwren = frame_ok && exact8
    && op_reg == `FSP_OP_VOL_WRITE_ENABLE;
  assign cmd_qen = frame_ok && exact8 && !quad
    && op_reg == `FSP_OP_QUAD_ENTRY;
  assign cmd_qex = frame_ok && exact8 && quad
    && op_reg == `FSP_OP_QUAD_EXIT;
  assign cmd_otp = frame_ok && exact8 && op_reg == `FSP_OP_OTP_ENTRY;

  // status write: latch or volatile enable, refused in protected mode
  assign cmd_status_write_cmd = frame_ok && exact16 && op_reg == `FSP_OP_STATUS_WRITE
    && (wel_reg || vol_en_reg) && !hardware_protected_mode;
  assign status_write_cmd_nv = cmd_status_write_cmd && !vol_en_reg;
  assign status_write_cmd_vol = cmd_status_write_cmd && vol_en_reg;
  assign tmr_start = status_write_cmd_nv;

  // array commands, all gated by the latch
  assign cmd_pp = frame_ok && wel_reg && op_reg == `FSP_OP_PAGE_PROGRAM
    && cnt_reg >= `FSP_BITS_PROGRAM_MIN;
  assign cmd_se = frame_ok && wel_reg && exact32
    && op_reg == `FSP_OP_SECTOR_ERASE;
  assign cmd_hbe = frame_ok && wel_reg && exact32
    && op_reg == `FSP_OP_HALF_BLOCK_ERASE;
  assign cmd_be = frame_ok && wel_reg && exact32
    && op_reg == `FSP_OP_BLOCK_ERASE;
  assign cmd_ce = frame_ok && wel_reg && exact8
    && op_reg == `FSP_OP_CHIP_ERASE
    && prot_reg.block_protect == 4'h0;
  assign cmd_arr = cmd_pp || cmd_se || cmd_hbe || cmd_be || cmd_ce;
  assign arr_kind = cmd_pp ? fsp_pkg::ARR_PROGRAM
    : cmd_se ? fsp_pkg::ARR_SECTOR_ERASE
    : cmd_hbe ? fsp_pkg::ARR_HALF_BLOCK_ERASE
    : cmd_be ? fsp_pkg::ARR_BLOCK_ERASE
    : fsp_pkg::ARR_CHIP_ERASE;

  // status write lands now (volatile) or at the end of the timed cycle
  assign apply_now = status_write_cmd_vol || tmr_done;
  assign apply_data = status_write_cmd_vol ? data_reg : pend_data_reg;
  assign apply_otp = status_write_cmd_vol ? otp : pend_otp_reg;

  // one-time bits only set; boot lock freezes the two selects
  assign otp_merged = '{
    security_lock_0: otp_reg.security_lock_0
      || apply_data[`FSP_SR_SECURITY_LOCK_0],
    pin_disable: otp_reg.pin_disable || apply_data[`FSP_SR_PIN_DISABLE],
    granularity_select: otp_reg.granularity_select
      || (apply_data[`FSP_SR_GRAN] && !prot_reg.boot_lock_enable),
    top_bottom_select: otp_reg.top_bottom_select
      || (apply_data[`FSP_SR_TB] && !prot_reg.boot_lock_enable),
    security_lock_1: otp_reg.security_lock_1
      || apply_data[`FSP_SR_SECURITY_LOCK_1],
    security_lock_2: otp_reg.security_lock_2
      || apply_data[`FSP_SR_SECURITY_LOCK_2]
  };

  // pending status write data held across the timed cycle
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      pend_data_reg <= 8'h00;
      pend_otp_reg <= 1'b0;
    end
    else if (status_write_cmd_nv)
    begin
      pend_data_reg <= data_reg;
      pend_otp_reg <= otp;
    end
  end

  // protection fields, bits one and zero never taken from data in the normal layout, bits five and zero in the one-time layout
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      prot_reg <= '0;
      otp_reg <= '0;
    end
    else if (apply_now && apply_otp)
      otp_reg <= otp_merged;
    else if (apply_now)
      prot_reg <= '{
        status_lock: apply_data[`FSP_SR_SRP],
        boot_lock_enable: apply_data[`FSP_SR_EBL],
        block_protect: apply_data[`FSP_SR_BP_HI:`FSP_SR_BP_LO]
      };
  end

  // write enable latch: set by write-enable, cleared on completion
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      wel_reg <= 1'b0;
    else if (tmr_done || arr_done_in)
      wel_reg <= 1'b0;
    else if (cmd_write_enable_cmd)
      wel_reg <= 1'b1;
    else if (cmd_write_disable_cmd && !otp)
      wel_reg <= 1'b0;
  end

  // volatile enable lasts until the next frame of eight bits or more that ends while idle
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      vol_en_reg <= 1'b0;
    else if (cmd_vwren)
      vol_en_reg <= 1'b1;
    else if (frame_ok && cnt_reg >= `FSP_BITS_OPCODE)
      vol_en_reg <= 1'b0;
  end

  // operating modes
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      mode_reg <= fsp_pkg::MODE_NORMAL;
      width_reg <= fsp_pkg::WIDTH_SINGLE;
    end
    else
    begin
      if (cmd_otp)
        mode_reg <= fsp_pkg::MODE_OTP;
      else if (cmd_write_disable_cmd && otp)
        mode_reg <= fsp_pkg::MODE_NORMAL;
      if (cmd_qen)
        width_reg <= fsp_pkg::WIDTH_QUAD;
      else if (cmd_qex)
        width_reg <= fsp_pkg::WIDTH_SINGLE;
    end
  end

  // array request toward the datapath
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      arr_busy_reg <= 1'b0;
      arr_start_reg <= 1'b0;
      req_reg <= '0;
    end
    else
    begin
      arr_start_reg <= cmd_arr;
      if (cmd_arr)
      begin
        arr_busy_reg <= 1'b1;
        req_reg <= '{kind: arr_kind, addr: addr_reg};
      end
      else if (arr_done_in)
        arr_busy_reg <= 1'b0;
    end
  end

  // outputs
  assign arr_start_out = arr_start_reg;
  assign arr_req_out = req_reg;
  assign prot_out = prot_reg;
  assign otp_out = otp_reg;
  assign write_enable_latch_out = wel_reg;
  assign write_in_progress_out = write_in_progress;
  assign hardware_protected_mode_out = hardware_protected_mode;
  assign quad_peripheral_mode_out = quad;
  assign otp_mode_out = otp;
  assign link_hold_out = hold;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_nv_write;
    status_write_cmd_nv ##1 tmr_busy [*3];
  endsequence

  a_write_disable_cmd_clears_wel: assert property (
    cmd_write_disable_cmd && !otp && !cmd_write_enable_cmd |=> !wel_reg)
    else $error("write-disable left latch set");
  a_write_disable_cmd_exits_otp: assert property (
    cmd_write_disable_cmd && otp |=> !otp && wel_reg == $past(wel_reg))
    else $error("write-disable did not leave one-time mode");
  a_write_enable_cmd_sets_wel: assert property (
    cmd_write_enable_cmd |=> wel_reg)
    else $error("write-enable did not set latch");
  a_done_clears_wel: assert property (
    tmr_done || arr_done_in |=> !wel_reg)
    else $error("latch survived operation end");
  a_write_needs_wel: assert property (
    (tmr_start || cmd_arr) |-> wel_reg)
    else $error("write accepted without latch");
  a_wip_during_write: assert property (
    s_nv_write |-> write_in_progress_out && status_byte[0])
    else $error("busy flag low during status write");
  a_erase_bp_zero: assert property (
    cmd_ce |=> arr_start_out && req_reg.kind == fsp_pkg::ARR_CHIP_ERASE
      && prot_reg.block_protect == 4'h0)
    else $error("chip erase with protect bits set");
  a_erase_bp_refuse: assert property (
    cs_rise && exact8 && op_reg == `FSP_OP_CHIP_ERASE
      && prot_reg.block_protect != 4'h0 |=> !arr_start_out)
    else $error("chip erase started with protect bits set");
  a_no_latch_refuse: assert property (
    cs_rise && !write_in_progress && !wel_reg && !vol_en_reg
      |=> !arr_start_out && !tmr_busy)
    else $error("write or array op started without latch");
  a_hpm_blocks_write: assert property (
    cs_rise && hardware_protected_mode && !tmr_done |=> $stable(prot_reg) && !tmr_busy
      || $past(tmr_busy))
    else $error("status write taken in protected mode");
  a_lock_one_sticky: assert property (
    !$fell(otp_reg.security_lock_1))
    else $error("security lock 1 cleared");
  a_lock_two_sticky: assert property (
    !$fell(otp_reg.security_lock_2))
    else $error("security lock 2 cleared");
  a_boot_lock_hold: assert property (
    prot_reg.boot_lock_enable |=> !$rose(otp_reg.top_bottom_select)
      && !$rose(otp_reg.granularity_select))
    else $error("select changed under boot lock");
  a_tx_msb_first: assert property (
    sclk_fall && rd_active && tx_load && !quad
      |=> dout_reg[0] == $past(status_byte[7]) && dq_oe_out == 4'h2)
    else $error("status not msb first on DQ1");

endmodule
`default_nettype wire

/* File: hw/fsp_cfg.svh */
`ifndef FSP_CFG_SVH
`define FSP_CFG_SVH

// opcodes
`define FSP_OP_STATUS_WRITE 8'h01
`define FSP_OP_PAGE_PROGRAM 8'h02
`define FSP_OP_WRITE_DISABLE 8'h04
`define FSP_OP_READ_STATUS 8'h05
`define FSP_OP_WRITE_ENABLE 8'h06
`define FSP_OP_SECTOR_ERASE 8'h20
`define FSP_OP_QUAD_ENTRY 8'h38
`define FSP_OP_OTP_ENTRY 8'h3A
`define FSP_OP_VOL_WRITE_ENABLE 8'h50
`define FSP_OP_HALF_BLOCK_ERASE 8'h52
`define FSP_OP_CHIP_ERASE 8'hC7
`define FSP_OP_BLOCK_ERASE 8'hD8
`define FSP_OP_QUAD_EXIT 8'hFF

// frame lengths in bits
`define FSP_CNT_W 6
`define FSP_BITS_OPCODE 6'h08
`define FSP_BITS_STATUS_WRITE 6'h10
`define FSP_BITS_ADDR 6'h20
`define FSP_BITS_PROGRAM_MIN 6'h28
`define FSP_BITS_MAX 6'h3F
`define FSP_STEP_SINGLE 6'h01
`define FSP_STEP_QUAD 6'h04

// status byte positions, both layouts
`define FSP_SR_WIP 0
`define FSP_SR_WEL 1
`define FSP_SR_SECURITY_LOCK_2 1
`define FSP_SR_SECURITY_LOCK_1 2
`define FSP_SR_TB 3
`define FSP_SR_GRAN 4
`define FSP_SR_BP_HI 5
`define FSP_SR_BP_LO 2
`define FSP_SR_EBL 6
`define FSP_SR_PIN_DISABLE 6
`define FSP_SR_SRP 7
`define FSP_SR_SECURITY_LOCK_0 7

// pin synchroniser: {cs_n, guard_n, pause_n, sclk, dq[3:0]}
`define FSP_PIN_W 8
`define FSP_PIN_RST 8'hE0

// self-timed status write
`define FSP_CLK_PERIOD_NS 10
`define FSP_STATUS_WRITE_NS 5000000
`define FSP_STATUS_WRITE_CYCLES (`FSP_STATUS_WRITE_NS / `FSP_CLK_PERIOD_NS)
`define FSP_TIMER_W 32

`endif

/* File: hw/fsp_pkg.sv */
package fsp_pkg;

  // device operating layout
  typedef enum logic {MODE_NORMAL, MODE_OTP} fsp_mode_t;

  // link width
  typedef enum logic {WIDTH_SINGLE, WIDTH_QUAD} fsp_width_t;

  // array operation handed to the datapath
  typedef enum logic [2:0] {
    ARR_PROGRAM,
    ARR_SECTOR_ERASE,
    ARR_HALF_BLOCK_ERASE,
    ARR_BLOCK_ERASE,
    ARR_CHIP_ERASE
  } fsp_arr_kind_t;

  // normal-mode protection fields
  typedef struct packed {
    logic status_lock;
    logic boot_lock_enable;
    logic [3:0] block_protect;
  } fsp_prot_t;

  // one-time-program fields
  typedef struct packed {
    logic security_lock_0;
    logic pin_disable;
    logic granularity_select;
    logic top_bottom_select;
    logic security_lock_1;
    logic security_lock_2;
  } fsp_otp_t;

  // array request
  typedef struct packed {
    fsp_arr_kind_t kind;
    logic [23:0] addr;
  } fsp_arr_req_t;

endpackage

/* File: hw/fsp_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fsp_cfg.svh"
module fsp_pin_sync
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // raw pins and synced copy
  input wire logic [`FSP_PIN_W-1:0] raw_in,
  output logic [`FSP_PIN_W-1:0] sync_out
);

  logic [`FSP_PIN_W-1:0] meta_reg;
  logic [`FSP_PIN_W-1:0] sync_reg;

  // two-stage synchroniser, first stage read only by the second
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      meta_reg <= `FSP_PIN_RST;
      sync_reg <= `FSP_PIN_RST;
    end
    else
    begin
      meta_reg <= raw_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule
`default_nettype wire

/* File: hw/fsp_op_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fsp_cfg.svh"
module fsp_op_timer
#(
  parameter logic [`FSP_TIMER_W-1:0] CYCLES = `FSP_STATUS_WRITE_CYCLES
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // control
  input wire logic start_in,
  output logic busy_out,
  output logic done_out
);

  logic [`FSP_TIMER_W-1:0] cnt_reg;
  logic busy_reg;
  logic last;

  assign last = busy_reg && (cnt_reg == CYCLES - 1'b1);

  // counts one self-timed cycle, start ignored while busy
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
    end
    else if (start_in && !busy_reg)
    begin
      cnt_reg <= '0;
      busy_reg <= 1'b1;
    end
    else if (busy_reg)
    begin
      cnt_reg <= cnt_reg + 1'b1;
      busy_reg <= !last;
    end
  end

  assign busy_out = busy_reg;
  assign done_out = last;

endmodule
`default_nettype wire

/* File: tb/fsp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fsp_host_model
(
  // host side link pins
  output logic sclk_out,
  output logic select_n_out,
  output logic [3:0] dq_out,
  // resolved data lines
  input wire logic [3:0] dq_in
);
  // idle link: clock parked low, select high
  initial
  begin
    sclk_out = 1'b0;
    select_n_out = 1'b1;
    dq_out = 4'hA;
  end
  // one frame, msb first, data changed while clock low
  task automatic xfer(input logic [47:0] tx, input int nbits,
    input logic q, output logic [47:0] rx);
    int i;
    begin
      rx = '0;
      select_n_out = 1'b0;
      // keep link edges off the sampling clock edge
      #1;
      for (i = 0; i < nbits; i = i + (q ? 4 : 1))
      begin
        dq_out = q ? tx[47-i -: 4] : {~dq_out[3:1], tx[47-i]};
        #62.5;
        sclk_out = 1'b1;
        rx = q ? {rx[43:0], dq_in} : {rx[46:0], dq_in[1]};
        #62.5;
        sclk_out = 1'b0;
      end
      #62.5;
      select_n_out = 1'b1;
      dq_out = ~dq_out;
      #100;
    end
  endtask
endmodule
`default_nettype wire

/* File: tb/fsp_status_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module fsp_status_top_tb;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic guard_n = 1'b1;
  logic pause_n = 1'b1;
  logic arr_done = 1'b0;
  wire sclk;
  wire sel_n;
  wire [3:0] host_dq;
  wire [3:0] dev_dq;
  wire [3:0] dev_oe;
  wire [3:0] dq_line;
  wire arr_start;
  wire write_enable_latch;
  wire write_in_progress;
  wire hardware_protected_mode;
  wire qmode;
  wire otpm;
  wire hold;
  fsp_pkg::fsp_arr_req_t arr_req;
  fsp_pkg::fsp_prot_t prot;
  fsp_pkg::fsp_otp_t otp;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  int starts = 0;
  int left = 0;
  int seed = 89489;
  int k;
  logic [7:0] s;
  logic [7:0] s2;
  logic [7:0] d;
  // 100 MHz clock
  always #5 clk_in = ~clk_in;
  // wire level from both drivers
  assign dq_line = (dev_oe & dev_dq) | (~dev_oe & host_dq);
  fsp_host_model fsp_host_model_inst (.sclk_out(sclk),
    .select_n_out(sel_n), .dq_out(host_dq), .dq_in(dq_line));
  fsp_status_top #(.STATUS_WRITE_CYCLES(32'h190)) fsp_status_top_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk),
    .device_select_n_in(sel_n), .dq_in(dq_line), .dq_out(dev_dq),
    .dq_oe_out(dev_oe), .write_guard_n_in(guard_n),
    .pause_n_in(pause_n), .arr_start_out(arr_start),
    .arr_req_out(arr_req), .arr_done_in(arr_done), .prot_out(prot),
    .otp_out(otp), .write_enable_latch_out(write_enable_latch),
    .write_in_progress_out(write_in_progress), .hardware_protected_mode_out(hardware_protected_mode),
    .quad_peripheral_mode_out(qmode), .otp_mode_out(otpm),
    .link_hold_out(hold));
  // array datapath stand-in: finishes 300 cycles after start
  always @(negedge clk_in)
  begin
    arr_done = (left == 1);
    if (left > 0)
      left = left - 1;
    if (arr_start === 1'b1)
    begin
      starts = starts + 1;
      left = 300;
    end
  end
  // hang guard
  always @(posedge clk_in)
  begin
    cycles = cycles + 1;
    if (cycles == 60000)
    begin
      bad_count = bad_count + 1;
      stop_test();
    end
  end
  task automatic stop_test();
    if (bad_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] got,
    input logic [7:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // expected status after an accepted normal write
  function automatic logic [7:0] wr_exp(input logic [7:0] v);
    return {v[7:2], 2'b00};
  endfunction
  task automatic cmd(input logic [7:0] op, input logic [7:0] v = 8'h00,
    input int n = 8, input logic q = 1'b0);
    logic [47:0] rx;
    @(negedge clk_in);
    fsp_host_model_inst.xfer({op, v, 32'h0}, n, q, rx);
  endtask
  // status read of two back-to-back bytes
  task automatic rd(output logic [7:0] a, output logic [7:0] b,
    input logic q = 1'b0);
    logic [47:0] rx;
    @(negedge clk_in);
    fsp_host_model_inst.xfer({8'h05, 40'h0}, 24, q, rx);
    a = rx[15:8];
    b = rx[7:0];
  endtask
  task automatic poll(output logic [7:0] a);
    logic [7:0] b;
    int i;
    for (i = 0; i < 20; i++)
    begin
      rd(a, b);
      if (a[0] === 1'b0)
        break;
    end
  endtask
  initial
  begin
    repeat (12) @(posedge clk_in);
    @(negedge clk_in) rst_n_in = 1'b1;
    repeat (3) @(negedge clk_in);
    rd(s, s2);
    check("reset status", s, 8'h00);
    cmd(8'h06);
    rd(s, s2);
    check("latch set", s, 8'h02);
    check("latch out", {7'h00, write_enable_latch}, 8'h01);
    check("repeat byte", s2, 8'h02);
    cmd(8'h04);
    rd(s, s2);
    check("latch clear", s, 8'h00);
    cmd(8'h01, 8'hFC, 16);
    rd(s, s2);
    check("no latch write", s, 8'h00);
    // random writes, first one all ones, last one locks bp
    for (k = 0; k < 5; k++)
    begin
      d = (k == 0) ? 8'hFF : (k == 4) ? 8'hBC : 8'($random(seed));
      cmd(8'h06);
      cmd(8'h01, d, 16);
      rd(s, s2);
      check("busy flag", {7'h00, s[0]}, 8'h01);
      check("busy out", {7'h00, write_in_progress}, 8'h01);
      poll(s);
      check("written status", s, wr_exp(d));
      check("prot out", {2'b00, prot}, {2'b00, d[7:2]});
    end
    @(negedge clk_in) guard_n = 1'b0;
    repeat (5) @(negedge clk_in);
    check("hpm", {7'h00, hardware_protected_mode}, 8'h01);
    cmd(8'h06);
    cmd(8'h01, 8'h00, 16);
    rd(s, s2);
    check("hpm refuse", s, 8'hBE);
    cmd(8'hC7);
    check("erase refused", 8'(starts), 8'h00);
    @(negedge clk_in) guard_n = 1'b1;
    cmd(8'h01, 8'h00, 16);
    poll(s);
    cmd(8'h06);
    cmd(8'hC7);
    check("erase start", 8'(starts), 8'h01);
    check("erase kind", {5'h00, arr_req.kind},
      {5'h00, fsp_pkg::ARR_CHIP_ERASE});
    rd(s, s2);
    check("erase busy", s, 8'h03);
    poll(s);
    check("erase done", s, 8'h00);
    cmd(8'h20, 8'h5A, 32);
    check("sector refused", 8'(starts), 8'h01);
    cmd(8'h06);
    cmd(8'h20, 8'h5A, 32);
    check("sector start", 8'(starts), 8'h02);
    check("sector kind", {5'h00, arr_req.kind},
      {5'h00, fsp_pkg::ARR_SECTOR_ERASE});
    check("sector addr", arr_req.addr[23:16], 8'h5A);
    poll(s);
    check("sector done", s, 8'h00);
    // volatile write also sets boot lock for the one-time part
    cmd(8'h50);
    cmd(8'h01, 8'h4C, 16);
    rd(s, s2);
    check("volatile write", s, 8'h4C);
    cmd(8'h38);
    check("quad on", {7'h00, qmode}, 8'h01);
    cmd(8'h06, 8'h00, 8, 1'b1);
    rd(s, s2, 1'b1);
    check("quad latch", s, 8'h4E);
    cmd(8'h04, 8'h00, 8, 1'b1);
    rd(s, s2, 1'b1);
    check("quad disable", s, 8'h4C);
    cmd(8'hFF, 8'h00, 8, 1'b1);
    cmd(8'h3A);
    cmd(8'h06);
    // selects asked for but frozen by boot lock
    cmd(8'h01, 8'h5E, 16);
    poll(s);
    check("otp status", s, 8'h46);
    check("otp fields", {2'b00, otp}, 8'h13);
    @(negedge clk_in) pause_n = 1'b0;
    repeat (5) @(negedge clk_in);
    check("pause ignored", {7'h00, hold}, 8'h00);
    pause_n = 1'b1;
    cmd(8'h04);
    check("otp exit", {7'h00, otpm}, 8'h00);
    rd(s, s2);
    check("normal layout", s, 8'h4C);
    stop_test();
  end
endmodule
`default_nettype wire
